// file: pkg/lpfs_pkg.sv
// operating-mode controller constants, types and register map
// assumes a 40 MHz core clock and a single AHB-Lite slave port
// Contract
// - sleep ignores all serial configuration commands
// - sleep wake goes restart-normal, records source
// - sleep with no wake source restarts instead
// - pending wake flags make sleep wake immediately
// - reset output low on sleep command
// - io undervoltage restarts; fourth one fail-safe
// - overvoltage reset: cfg1/3 restart, watchdog_fail_config/4 fail-safe
// - restart leaves after uv clear and delay
// - restart and fail-safe exit keep fail output
// - restart status: 01 fault, 10 sleep wake
// - fail-safe turns supplies off, fail on
// - fail-safe causes: thermal, watchdog, short, long uv
// - fail-safe enables default wakes, clears flags
// - fail-safe minimum dwell, wakes stored then restart
// - fail-safe: wakes capable, cyclic off, modulation cleared
// - fail-safe return status and cause flags
// - development mode halts watchdog failures only
// - development mode: transceivers on during init
// - development entry: pin low through init, command
// - development left by power-down or software reset
// - fail/test pull-up only during init
// - watchdog config kept until power-down
// - any command in init goes normal
package lpfs_pkg;
    localparam int unsigned CLK_HZ            = 40_000_000;
    localparam int unsigned RESET_DELAY_US    = 10;
    localparam int unsigned FAILSAFE_MIN_MS   = 100;
    localparam int unsigned THERMAL_MIN_MS    = 1000;
    localparam int unsigned RESET_DELAY_CYC   =
        (RESET_DELAY_US * (CLK_HZ / 1_000_000));
    localparam int unsigned FAILSAFE_MIN_CYC  =
        (FAILSAFE_MIN_MS * (CLK_HZ / 1000));
    localparam int unsigned THERMAL_MIN_CYC   =
        (THERMAL_MIN_MS * (CLK_HZ / 1000));
    localparam int unsigned UV_FAILSAFE_COUNT = 4;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] WAKE_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] CLEAR_OFS  = 8'h0c;
    // control register fields
    localparam int CTRL_MODE_LSB = 0; // 2-bit mode request
    localparam int CTRL_OVRST    = 2;
    localparam int CTRL_FAILON   = 3;
    localparam int CTRL_EXTON    = 4;
    // wake enable register fields
    localparam int WEN_BUS   = 0;
    localparam int WEN_PIN   = 1;
    localparam int WEN_CYC   = 2;
    localparam int WEN_MOD   = 3;
    localparam logic [3:0] WEN_DEFAULT = 4'h3;
    // mode request codes and restart status codes
    localparam logic [1:0] REQ_NORMAL = 2'h0;
    localparam logic [1:0] REQ_STOP   = 2'h1;
    localparam logic [1:0] REQ_SLEEP  = 2'h2;
    localparam logic [1:0] REQ_SWRST  = 2'h3;
    localparam logic [1:0] DS_FAULT   = 2'h1;
    localparam logic [1:0] DS_WAKE    = 2'h2;

    typedef enum logic [2:0] {
        LPFS_INIT     = 3'h0,
        LPFS_NORMAL   = 3'h1,
        LPFS_STOP     = 3'h2,
        LPFS_SLEEP    = 3'h3,
        LPFS_RESTART  = 3'h4,
        LPFS_FAILSAFE = 3'h5
    } lpfs_mode_e;

    typedef struct packed {
        logic thermal;
        logic watchdog_fail_count;
        logic uv;
        logic ov;
        logic short_gnd;
        logic uv_long;
    } lpfs_fault_s;

    typedef struct packed {
        logic [1:0] htrans;
        logic       hwrite;
        logic       hsel;
        logic [7:0] haddr;
    } lpfs_aphase_s;

    typedef struct packed {
        logic [1:0]  sync;
        lpfs_mode_e  mode;
        logic [31:0] cnt;
        logic        thermal_hold;
        logic [2:0]  uv_count;
        logic [1:0]  wd_count;
        logic        cfg_valid;
        logic        wd_single;
        logic        wd_to_fs;
        logic        dev_mode;
        logic        pin_low_all;
        logic        ctrl_ov;
        logic        ctrl_fail;
        logic        ctrl_ext;
        logic [3:0]  wen;
        logic [1:0]  wake_flags;
        logic [1:0]  dev_status;
        logic [1:0]  watchdog_fail_count_count;
        logic        uv_flag;
        logic        ov_flag;
        logic        short_flag;
        logic        thermal_flag;
        logic        fail_out;
        logic        rst_n;
        logic        dphase_wr;
        logic [7:0]  dphase_addr;
        logic [31:0] rdata;
    } lpfs_state_s;
endpackage

// file: core/lpfs_mode_fsm.sv
// operating-mode state machine with AHB-Lite register slave
// assumes fault inputs are synchronous single-cycle or level indications
`timescale 1ns/100ps
`default_nettype none
module lpfs_mode_fsm
    import lpfs_pkg::*;
#(
    parameter int unsigned FAILSAFE_CYCLES = FAILSAFE_MIN_CYC,
    parameter int unsigned THERMAL_CYCLES  = THERMAL_MIN_CYC,
    parameter int unsigned RESET_CYCLES    = RESET_DELAY_CYC
)(
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    input  wire logic        hsel_i,
    input  wire logic [7:0]  haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic        bus_wake_i,
    input  wire logic        pin_wake_i,
    input  wire logic        watchdog_fail_count_i,
    input  wire logic        cfg_single_i,
    input  wire logic        cfg_restart_i,
    input  wire logic        io_uv_i,
    input  wire logic        io_ov_i,
    input  wire logic        io_short_i,
    input  wire logic        io_uv_long_i,
    input  wire logic        thermal_i,
    input  wire logic        fail_test_pin_i,
    output logic             fail_test_pullup_o,
    output logic             fail_output_o,
    output logic             reset_out_n_o,
    output logic             main_regulator_output_o,
    output logic             external_supply_output_o,
    output logic             bus_transceivers_on_o,
    output logic             cyclic_wake_en_o,
    output logic             wake_pin_modulation_select_o
);
    // refuse dwell counts that the counters cannot serve
    if (RESET_CYCLES < 1 || FAILSAFE_CYCLES < 1 || THERMAL_CYCLES < 1)
    begin : g_dwell_check
        $error("dwell counts must be at least one cycle");
    end

    lpfs_state_s r;
    lpfs_state_s n;
    logic        rst_n;
    logic        wr_take;
    logic        cmd;
    logic [1:0]  req;
    logic [1:0]  wake_now;
    logic        wd_eff;
    logic        ov_eff;

    // reset release through two flip-flops
    logic [1:0] rsync;
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rsync <= 2'h0;
        else
            rsync <= {rsync[0], 1'b1};
    end
    assign rst_n = rsync[1];

    // bus decode: a write data phase to the control offset is one command
    assign wr_take = r.dphase_wr && hready_i;
    assign cmd     = wr_take && (r.dphase_addr == CTRL_OFS);
    assign req     = hwdata_i[CTRL_MODE_LSB +: 2];
    assign wake_now = {pin_wake_i & r.wen[WEN_PIN],
                       bus_wake_i & r.wen[WEN_BUS]};
    assign wd_eff  = watchdog_fail_count_i && !r.dev_mode;
    assign ov_eff  = io_ov_i && r.ctrl_ov;

    function automatic logic [31:0] dwell(input logic th);
        dwell = th ? THERMAL_CYCLES : FAILSAFE_CYCLES;
    endfunction

    // next-state logic for all state
    always_comb
    begin
        logic to_fs;
        logic to_rs;
        logic wd_hit;
        to_fs  = 1'b0;
        to_rs  = 1'b0;
        wd_hit = 1'b0;
        n = r;
        n.sync = 2'h0;
        n.dphase_wr = 1'b0;
        if (hready_i)
        begin
            n.dphase_wr   = hsel_i && htrans_i[1] && hwrite_i;
            n.dphase_addr = haddr_i;
            case (haddr_i)
                CTRL_OFS:   n.rdata = {27'h0, r.ctrl_ext, r.ctrl_fail,
                                       r.ctrl_ov, 2'h0};
                WAKE_OFS:   n.rdata = {28'h0, r.wen};
                STATUS_OFS: n.rdata = {16'h0, r.dev_mode, r.wd_to_fs,
                                       r.wd_single, r.mode,
                                       r.thermal_flag, r.short_flag,
                                       r.ov_flag, r.uv_flag,
                                       r.watchdog_fail_count_count, r.dev_status,
                                       r.wake_flags};
                default:    n.rdata = 32'h0;
            endcase
        end
        if (r.cnt != 32'h0)
            n.cnt = r.cnt - 32'h1;
        // watchdog config caught once after power-on release
        if (!r.cfg_valid)
        begin
            n.cfg_valid = 1'b1;
            n.wd_single = cfg_single_i;
            n.wd_to_fs  = !cfg_restart_i;
        end
        // latched events are sticky; set wins over clear
        if (wr_take && r.dphase_addr == CLEAR_OFS && r.mode != LPFS_SLEEP)
            n.wake_flags = r.wake_flags & ~hwdata_i[1:0];
        if (wr_take && r.dphase_addr == WAKE_OFS && r.mode != LPFS_SLEEP)
            n.wen = hwdata_i[3:0];
        n.wake_flags = n.wake_flags | wake_now;
        if (wd_eff)
        begin
            wd_hit = r.wd_single || r.wd_count != 2'h0;
            n.wd_count = wd_hit ? 2'h0 : 2'h1;
        end
        case (r.mode)
            LPFS_INIT:
            begin
                if (!fail_test_pin_i && r.rst_n)
                    n.pin_low_all = r.pin_low_all;
                else if (r.rst_n)
                    n.pin_low_all = 1'b0;
                n.cnt = (r.cnt == 32'h0) ? 32'h0 : r.cnt - 32'h1;
                if (!r.rst_n && r.cnt == 32'h0 && !io_uv_i)
                    n.rst_n = 1'b1;
                if (cmd)
                begin
                    n.mode = LPFS_NORMAL;
                    n.dev_mode = r.pin_low_all;
                end
            end
            LPFS_NORMAL, LPFS_STOP:
            begin
                if (cmd)
                begin
                    n.ctrl_ov   = hwdata_i[CTRL_OVRST];
                    n.ctrl_fail = hwdata_i[CTRL_FAILON];
                    n.ctrl_ext  = hwdata_i[CTRL_EXTON];
                end
                if (thermal_i || io_short_i || io_uv_long_i)
                    to_fs = 1'b1;
                else if (wd_hit)
                begin
                    n.watchdog_fail_count_count = r.wd_single ? 2'h1 : 2'h2;
                    n.fail_out = 1'b1;
                    if (r.wd_to_fs)
                        to_fs = 1'b1;
                    else
                    begin
                        to_rs = 1'b1;
                        n.watchdog_fail_count_count = 2'h1;
                    end
                end
                else if (io_uv_i)
                begin
                    n.uv_flag = 1'b1;
                    if (r.uv_count == 3'(UV_FAILSAFE_COUNT - 1))
                        to_fs = 1'b1;
                    else
                    begin
                        n.uv_count = r.uv_count + 3'h1;
                        to_rs = 1'b1;
                    end
                end
                else if (ov_eff)
                begin
                    n.ov_flag = 1'b1;
                    n.fail_out = 1'b1;
                    to_fs = r.wd_to_fs;
                    to_rs = !r.wd_to_fs;
                end
                else if (cmd && req == REQ_SLEEP && r.mode == LPFS_NORMAL)
                begin
                    n.rst_n = 1'b0;
                    if (r.wen[1:0] == 2'h0 || r.wake_flags != 2'h0)
                    begin
                        n.mode = LPFS_RESTART;
                        n.dev_status = DS_WAKE;
                        n.cnt = RESET_CYCLES;
                    end
                    else
                        n.mode = LPFS_SLEEP;
                end
                else if (cmd && req == REQ_SWRST)
                begin
                    n.dev_mode = 1'b0;
                    n.rst_n = 1'b0;
                    n.mode = LPFS_INIT;
                    n.pin_low_all = 1'b1;
                    n.cnt = RESET_CYCLES;
                end
                else if (cmd && req == REQ_STOP)
                    n.mode = LPFS_STOP;
                else if (cmd && req == REQ_NORMAL)
                    n.mode = LPFS_NORMAL;
                if (thermal_i)
                    n.thermal_flag = 1'b1;
                if (io_short_i)
                begin
                    n.short_flag = 1'b1;
                    n.uv_flag = 1'b1;
                end
                if (to_rs)
                begin
                    n.mode = LPFS_RESTART;
                    n.rst_n = 1'b0;
                    n.dev_status = DS_FAULT;
                    n.cnt = RESET_CYCLES;
                end
            end
            LPFS_SLEEP:
            begin
                if (thermal_i)
                begin
                    to_fs = 1'b1;
                    n.thermal_flag = 1'b1;
                end
                else if (wake_now != 2'h0)
                begin
                    n.mode = LPFS_RESTART;
                    n.dev_status = DS_WAKE;
                    n.cnt = RESET_CYCLES;
                end
            end
            LPFS_RESTART:
            begin
                // fail output untouched here
                if (io_uv_i)
                    n.cnt = RESET_CYCLES;
                else if (r.cnt == 32'h0)
                begin
                    n.mode = LPFS_NORMAL;
                    n.rst_n = 1'b1;
                    if (!io_uv_i && r.dev_status == DS_WAKE)
                        n.uv_count = 3'h0;
                end
            end
            LPFS_FAILSAFE:
            begin
                if (thermal_i)
                begin
                    n.thermal_hold = 1'b1;
                    n.cnt = dwell(1'b1);
                end
                if (r.cnt == 32'h0 && !thermal_i && r.wake_flags != 2'h0)
                begin
                    n.mode = LPFS_RESTART;
                    n.dev_status = DS_FAULT;
                    n.uv_count = 3'h0;
                    n.cnt = RESET_CYCLES;
                end
            end
            default: n.mode = LPFS_INIT;
        endcase
        if (to_fs)
        begin
            n.mode = LPFS_FAILSAFE;
            n.rst_n = 1'b0;
            n.fail_out = 1'b1;
            n.wen = WEN_DEFAULT;
            n.wake_flags = 2'h0;
            n.thermal_hold = thermal_i;
            n.cnt = dwell(thermal_i);
            n.dev_status = DS_FAULT;
        end
        if (cmd && (r.mode == LPFS_NORMAL) && !to_fs && !wd_hit)
            n.fail_out = hwdata_i[CTRL_FAILON] | r.fail_out & !r.ctrl_fail;
    end

    // one register stage for all state
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.mode <= LPFS_INIT;
            r.pin_low_all <= 1'b1;
            r.cnt <= 32'(RESET_CYCLES);
            r.wen <= WEN_DEFAULT;
        end
        else
            r <= n;
    end

    // outputs
    assign hrdata_o    = r.rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign fail_test_pullup_o = (r.mode == LPFS_INIT);
    assign fail_output_o  = r.fail_out;
    assign reset_out_n_o  = r.rst_n;
    assign main_regulator_output_o = (r.mode != LPFS_SLEEP) &&
                                     (r.mode != LPFS_FAILSAFE);
    assign external_supply_output_o = r.ctrl_ext &&
                                      (r.mode != LPFS_FAILSAFE);
    assign bus_transceivers_on_o = (r.mode == LPFS_INIT) ? r.pin_low_all
                                   : r.wen[WEN_BUS];
    assign cyclic_wake_en_o = r.wen[WEN_CYC];
    assign wake_pin_modulation_select_o = r.wen[WEN_MOD];

    fs_reset_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        n.mode == LPFS_FAILSAFE && r.mode != LPFS_FAILSAFE |=>
        !reset_out_n_o && fail_output_o && !main_regulator_output_o)
        else $error("fail-safe entry outputs wrong");
    fs_wake_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        r.mode != LPFS_FAILSAFE ##1 r.mode == LPFS_FAILSAFE |->
        r.wen == WEN_DEFAULT && r.wake_flags == 2'h0)
        else $error("fail-safe wake setup wrong");
    sleep_rst_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        cmd && req == REQ_SLEEP && r.mode == LPFS_NORMAL && !to_fs_any()
        |=> !reset_out_n_o)
        else $error("reset not low after sleep request");
    sleep_wake_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        r.mode == LPFS_SLEEP && wake_now != 2'h0 && !thermal_i |=>
        r.mode == LPFS_RESTART && r.dev_status == DS_WAKE)
        else $error("sleep wake missed");
    fail_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        r.mode == LPFS_RESTART |=> fail_output_o == $past(fail_output_o))
        else $error("fail output changed in restart");
    pullup_init_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        fail_test_pullup_o |-> r.mode == LPFS_INIT)
        else $error("pull-up outside init");
    dev_wd_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        r.dev_mode && r.mode == LPFS_NORMAL && watchdog_fail_count_i && !thermal_i
        && !io_short_i && !io_uv_long_i && !io_uv_i && !ov_eff && !cmd
        |=> r.mode == LPFS_NORMAL)
        else $error("watchdog acted in development mode");
    init_cmd_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        r.mode == LPFS_INIT && cmd |=> r.mode == LPFS_NORMAL)
        else $error("init ignored a command");

    function automatic logic to_fs_any();
        to_fs_any = thermal_i || io_short_i || io_uv_long_i ||
                    (wd_eff && (r.wd_single || r.wd_count != 2'h0)) ||
                    io_uv_i || ov_eff;
    endfunction
endmodule
`default_nettype wire

// file: sim/lpfs_host.sv
// microcontroller stand-in: single-word AHB-Lite master
// assumes one slave whose hreadyout is the bus hready
`timescale 1ns/100ps
`default_nettype none
module lpfs_host (
    input  wire logic        clk_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_i,
    output logic             hsel_o,
    output logic [7:0]       haddr_o,
    output logic [1:0]       htrans_o,
    output logic             hwrite_o,
    output logic [2:0]       hsize_o,
    output logic [31:0]      hwdata_o
);
    // bus idle at time zero
    initial
    begin
        hsel_o = 1'b0;
        haddr_o = 8'h00;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
    end

    // one transfer: hold address until hready, then data until hready
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        hsel_o <= 1'b1;
        haddr_o <= a;
        htrans_o <= 2'h2;
        hwrite_o <= w;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        hsel_o <= 1'b0;
        htrans_o <= 2'h0;
        hwdata_o <= d;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        r = hrdata_i;
        haddr_o <= ~a;   // released lines show no stale value
        hwdata_o <= ~d;
    endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the operating-mode controller
// assumes the host model drives the register bus
`timescale 1ns/100ps
`default_nettype none
module tb
    import lpfs_pkg::*;
();
    localparam int unsigned FS = 20;
    localparam int unsigned TH = 80;
    localparam int unsigned RD = 8;
    logic        clock_i, nrst_i, hsel, hwrite, hrdy, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rv;
    logic [7:0]  ev;
    logic        cfg_s, cfg_r, pin, pull, fo, rst_n, vcc, external_supply_output, bon;
    logic        cyc, mods;
    int          failures, checks, k;
    int unsigned cyc_n;

    // clock and time-zero input values
    initial
    begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    initial
    begin
        nrst_i = 1'b0;
        ev = 8'h00;
        cfg_s = 1'b1;
        cfg_r = 1'b1;
        pin = 1'b1;
        failures = 0;
        checks = 0;
        cyc_n = 0;
    end

    lpfs_host u_host (.clk_i(clock_i), .hready_i(hrdy), .hrdata_i(hrdata),
        .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
        .hsize_o(hsize), .hwdata_o(hwdata));

    lpfs_mode_fsm #(.FAILSAFE_CYCLES(FS), .THERMAL_CYCLES(TH),
        .RESET_CYCLES(RD)) u_dut (.clock_i(clock_i), .nrst_i(nrst_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
        .hresp_o(hresp), .bus_wake_i(ev[0]), .pin_wake_i(ev[1]),
        .watchdog_fail_count_i(ev[2]), .cfg_single_i(cfg_s), .cfg_restart_i(cfg_r),
        .io_uv_i(ev[3]), .io_ov_i(ev[4]), .io_short_i(ev[5]),
        .io_uv_long_i(ev[6]), .thermal_i(ev[7]), .fail_test_pin_i(pin),
        .fail_test_pullup_o(pull), .fail_output_o(fo),
        .reset_out_n_o(rst_n), .main_regulator_output_o(vcc),
        .external_supply_output_o(external_supply_output), .bus_transceivers_on_o(bon),
        .cyclic_wake_en_o(cyc), .wake_pin_modulation_select_o(mods));

    task automatic stop_test;
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // hang guard
    always @(posedge clock_i)
    begin
        cyc_n++;
        if (cyc_n == 30000)
        begin
            failures++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rv);
    endtask

    // status read; mode field compared with the expected mode
    task automatic mode_is(input lpfs_mode_e m);
        u_host.xfer(1'b0, STATUS_OFS, 32'h0, rv);
        chk("mode", 32'(rv[12:10]), 32'(m));
    endtask

    // one-cycle event on input n, then let it settle
    task automatic pulse(input int n);
        ev <= 8'h01 << n;
        @(posedge clock_i);
        ev <= 8'h00;
        repeat (3) @(posedge clock_i);
    endtask

    task automatic wait_rst(input logic v);
        int n;
        n = 0;
        while (rst_n !== v && n < 400)
        begin
            @(posedge clock_i);
            n++;
        end
        chk("reset_out_n", 32'(rst_n), 32'(v));
    endtask

    // restart pass: reset low, then released back into normal
    task automatic restart;
        wait_rst(1'b0);
        wait_rst(1'b1);
        mode_is(LPFS_NORMAL);
    endtask

    task automatic do_reset(input logic s, input logic r, input logic p);
        nrst_i <= 1'b0;
        cfg_s <= s;
        cfg_r <= r;
        pin <= p;
        repeat (12) @(posedge clock_i);
        nrst_i <= 1'b1;
        wait_rst(1'b1);
        mode_is(LPFS_INIT);
        chk("pullup", 32'(pull), 32'h1);
        chk("bus_on", 32'(bon), 32'(!p));
        chk("hresp", 32'(hresp), 32'h0);
    endtask

    task automatic fs_check;
        mode_is(LPFS_FAILSAFE);
        chk("wake_flags", 32'(rv[1:0]), 32'h0);
        chk("supplies", 32'({vcc, external_supply_output}), 32'h0);
        chk("fail_output", 32'(fo), 32'h1);
        chk("cyclic_mod", 32'({cyc, mods}), 32'h0);
        u_host.xfer(1'b0, WAKE_OFS, 32'h0, rv);
        chk("wake_en", 32'(rv[1:0]), 32'(WEN_DEFAULT[1:0]));
    endtask

    task automatic fs_exit(input int unsigned t);
        repeat (t + $urandom_range(3)) @(posedge clock_i);
        pulse(1);
        restart();
        chk("fail_output", 32'(fo), 32'h1);
        chk("dev_status", 32'(rv[3:2]), 32'(DS_FAULT));
    endtask

    // main sequence
    initial
    begin
        void'($urandom(32'h6b7c320a));
        do_reset(1'b1, 1'b1, 1'b1);
        wr(CTRL_OFS, {28'h0, 1'($urandom_range(1)), 3'h0});
        mode_is(LPFS_NORMAL);
        chk("pullup", 32'(pull), 32'h0);
        for (k = 1; k <= UV_FAILSAFE_COUNT; k++)
        begin
            pulse(3);
            if (k < UV_FAILSAFE_COUNT)
                restart();
        end
        fs_check();
        fs_exit(FS);
        chk("uv_flag", 32'(rv[6]), 32'h1);
        pulse(2);
        restart();
        chk("wd_count", 32'(rv[5:4]), 32'h1);
        wr(CTRL_OFS, 32'h1 << CTRL_OVRST);
        pulse(4);
        restart();
        chk("ov_flag", 32'(rv[7]), 32'h1);
        chk("dev_status", 32'(rv[3:2]), 32'(DS_FAULT));
        wr(CLEAR_OFS, 32'h3);
        wr(CTRL_OFS, 32'(REQ_SLEEP));
        repeat (2) @(posedge clock_i);
        chk("reset_out_n", 32'(rst_n), 32'h0);
        wr(WAKE_OFS, 32'h0);
        pulse(0);
        restart();
        chk("wake_flags", 32'(rv[1:0]), 32'h1);
        chk("dev_status", 32'(rv[3:2]), 32'(DS_WAKE));
        u_host.xfer(1'b0, WAKE_OFS, 32'h0, rv);
        chk("wake_en", 32'(rv[3:0]), 32'(WEN_DEFAULT));
        wr(CTRL_OFS, 32'(REQ_SLEEP));
        restart();
        wr(CLEAR_OFS, 32'h3);
        wr(WAKE_OFS, 32'h0);
        wr(CTRL_OFS, 32'(REQ_SLEEP));
        restart();
        do_reset(1'b0, 1'b0, 1'b0);
        wr(CTRL_OFS, 32'h0);
        mode_is(LPFS_NORMAL);
        chk("dev_mode", 32'(rv[15]), 32'h1);
        pulse(2);
        pulse(2);
        mode_is(LPFS_NORMAL);
        chk("reset_out_n", 32'(rst_n), 32'h1);
        wr(WAKE_OFS, 32'hf);
        pulse(7);
        fs_check();
        fs_exit(TH);
        pin <= 1'b1;
        cfg_s <= 1'b1;
        cfg_r <= 1'b1;
        wr(CTRL_OFS, 32'(REQ_SWRST));
        wait_rst(1'b0);
        wait_rst(1'b1);
        mode_is(LPFS_INIT);
        wr(CTRL_OFS, 32'h0);
        mode_is(LPFS_NORMAL);
        chk("dev_mode", 32'(rv[15]), 32'h0);
        chk("wd_cfg", 32'(rv[14:13]), 32'h2);
        pulse(2);
        pulse(2);
        fs_check();
        fs_exit(FS);
        chk("wd_count", 32'(rv[5:4]), 32'h2);
        pulse(7);
        fs_check();
        repeat (FS + 5) @(posedge clock_i);
        pulse(1);
        mode_is(LPFS_FAILSAFE);
        restart();
        chk("thermal_flag", 32'(rv[9]), 32'h1);
        wr(CTRL_OFS, (32'h1 << CTRL_OVRST) | (32'h1 << CTRL_EXTON) |
            32'(REQ_STOP));
        mode_is(LPFS_STOP);
        chk("ext_on", 32'(external_supply_output), 32'h1);
        pulse(4);
        fs_check();
        fs_exit(FS);
        pulse(5);
        fs_check();
        fs_exit(FS);
        chk("uv_short", 32'({rv[8], rv[6]}), 32'h3);
        pulse(6);
        fs_check();
        fs_exit(FS);
        stop_test();
    end
endmodule
`default_nettype wire
